// >>> bench/testbench.sv
// Self-checking bench for the 16-bit timer/counter
`timescale 1ns/100ps
module testbench;
   import timer_pkg::*;
   // ------------
   // Signals
   // ------------
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [2:0] s_axi_awprot = 3'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b1;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [2:0] s_axi_arprot = 3'h0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b1;
   logic sleep_mode = 1'b0;
   logic external_count_input = 1'b0;
   logic crystal_input_pin = 1'b0;
   logic crystal_output_pin;
   logic crystal_output_oe;
   logic [3:0] compare_one_mode = 4'h0;
   logic compare_one_match = 1'b0;
   logic [3:0] compare_two_mode = 4'h0;
   logic compare_two_match = 1'b0;
   logic overflow_irq;
   logic wake_request;
   int err_count = 0;
   int n_compared = 0;
   int seed = 78;
   logic [33:0] rq[$];
   logic cq[$];
   logic [1:0] bq[$];
   logic [33:0] e;
   logic [31:0] rd_val;
   logic [7:0] lo;
   logic [7:0] hi;

   always #12.5 aclk = ~aclk;

   timer_counter #(.ADDR_W(12)) dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .sleep_mode, .external_count_input,
      .crystal_input_pin, .crystal_output_pin, .crystal_output_oe,
      .compare_one_mode, .compare_one_match, .compare_two_mode,
      .compare_two_match, .overflow_irq, .wake_request);

   // ------------
   // Checking and bus tasks
   // ------------
   task automatic check(string what, logic [33:0] exp, logic [33:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Channels released one by one, since the slave may take either first
   task automatic wr(logic [7:0] idx, logic [7:0] d, logic [1:0] resp);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      bq.push_back(resp);
      s_axi_awaddr <= {2'b00, idx, 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // Own flags, since the valids only settle after this time step
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
   endtask

   task automatic rd(logic [7:0] idx, logic [1:0] resp, logic [7:0] d,
                     logic care);
      rq.push_back({resp, 24'h000000, d});
      cq.push_back(care);
      s_axi_araddr <= {2'b00, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd_val = s_axi_rdata;
   endtask

   // Slow edges, well inside the synchroniser's reach
   task automatic pulses(int n, logic xtal);
      repeat (n) begin
         repeat (4) @(posedge aclk);
         if (xtal) crystal_input_pin <= 1'b1;
         else external_count_input <= 1'b1;
         repeat (4) @(posedge aclk);
         crystal_input_pin <= 1'b0;
         external_count_input <= 1'b0;
      end
      repeat (6) @(posedge aclk);
   endtask

   // ------------
   // Response monitor
   // ------------
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && rq.size() > 0) begin
         e = rq.pop_front();
         if (cq.pop_front() !== 1'b1) e[31:0] = s_axi_rdata;
         check("read", e, {s_axi_rresp, s_axi_rdata});
      end
      if (s_axi_bvalid === 1'b1 && bq.size() > 0) begin
         check("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
      end
   end

   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      test_done();
   end

   // ------------
   // Scenarios
   // ------------
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(IDX_CONTROL, RESP_OKAY, CTL_RESET, 1'b1);
      rd(IDX_IRQ_FLAGS, RESP_OKAY, 8'h00, 1'b1);
      rd(IDX_IRQ_ENABLES, RESP_OKAY, 8'h00, 1'b1);
      rd(8'h01, RESP_SLVERR, 8'h00, 1'b1);
      wr(8'h01, 8'hff, RESP_SLVERR);
      wr(IDX_CONTROL, 8'hfe, RESP_OKAY);
      rd(IDX_CONTROL, RESP_OKAY, 8'h3e, 1'b1);
      wr(IDX_CONTROL, 8'h00, RESP_OKAY);
      wr(IDX_IRQ_ENABLES, 8'ha4, RESP_OKAY);
      rd(IDX_IRQ_ENABLES, RESP_OKAY, 8'ha4, 1'b1);
      wr(IDX_INT_CONTROL, 8'h5b, RESP_OKAY);
      rd(IDX_INT_CONTROL, RESP_OKAY, 8'h5b, 1'b1);
      $display("registers test done");
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      wr(IDX_COUNT_LOW, lo, RESP_OKAY);
      wr(IDX_COUNT_HIGH, hi, RESP_OKAY);
      repeat (20) @(posedge aclk);
      rd(IDX_COUNT_HIGH, RESP_OKAY, hi, 1'b1);
      rd(IDX_COUNT_LOW, RESP_OKAY, lo, 1'b1);
      rd(IDX_COUNT_HIGH, RESP_OKAY, hi, 1'b1);
      // Second reset: count kept, control cleared
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(IDX_COUNT_HIGH, RESP_OKAY, hi, 1'b1);
      rd(IDX_COUNT_LOW, RESP_OKAY, lo, 1'b1);
      rd(IDX_CONTROL, RESP_OKAY, 8'h00, 1'b1);
      $display("count bytes test done");
      // About 64 cycles of running; two cycles slack for bus latency
      for (int k = 0; k < 4; k++) begin
         wr(IDX_COUNT_LOW, 8'h00, RESP_OKAY);
         wr(IDX_COUNT_HIGH, 8'h00, RESP_OKAY);
         wr(IDX_CONTROL, {2'b00, 2'(k), 4'h1}, RESP_OKAY);
         repeat (61) @(posedge aclk);
         wr(IDX_CONTROL, 8'h00, RESP_OKAY);
         rd(IDX_COUNT_LOW, RESP_OKAY, 8'h00, 1'b0);
         check("prescale", 34'h1, 34'(rd_val <= (66 >> k) + 1 &&
               rd_val + 2 >= (64 >> k)));
      end
      $display("prescale test done");
      wr(IDX_IRQ_ENABLES, 8'h01, RESP_OKAY);
      wr(IDX_COUNT_LOW, 8'hff, RESP_OKAY);
      wr(IDX_COUNT_HIGH, 8'hff, RESP_OKAY);
      wr(IDX_CONTROL, 8'h01, RESP_OKAY);
      repeat (4) @(posedge aclk);
      wr(IDX_CONTROL, 8'h00, RESP_OKAY);
      rd(IDX_COUNT_HIGH, RESP_OKAY, 8'h00, 1'b1);
      rd(IDX_IRQ_FLAGS, RESP_OKAY, 8'h01, 1'b1);
      check("irq", 34'h1, 34'(overflow_irq));
      check("wake", 34'h0, 34'(wake_request));
      sleep_mode <= 1'b1;
      repeat (2) @(posedge aclk);
      check("wake", 34'h1, 34'(wake_request));
      sleep_mode <= 1'b0;
      repeat (30) @(posedge aclk);
      rd(IDX_IRQ_FLAGS, RESP_OKAY, 8'h01, 1'b1);
      wr(IDX_IRQ_FLAGS, 8'h00, RESP_OKAY);
      rd(IDX_IRQ_FLAGS, RESP_OKAY, 8'h00, 1'b1);
      check("irq", 34'h0, 34'(overflow_irq));
      $display("overflow test done");
      for (int u = 0; u < 2; u++) begin
         for (int m = 10; m < 12; m++) begin
            wr(IDX_COUNT_LOW, 8'h55, RESP_OKAY);
            wr(IDX_COUNT_HIGH, 8'h01, RESP_OKAY);
            compare_one_mode <= 4'(m);
            compare_two_mode <= 4'(m);
            @(posedge aclk);
            if (u == 0) compare_one_match <= 1'b1;
            else compare_two_match <= 1'b1;
            @(posedge aclk);
            compare_one_match <= 1'b0;
            compare_two_match <= 1'b0;
            @(posedge aclk);
            lo = (m == 11) ? 8'h00 : 8'h55;
            hi = (m == 11) ? 8'h00 : 8'h01;
            rd(IDX_COUNT_HIGH, RESP_OKAY, hi, 1'b1);
            rd(IDX_COUNT_LOW, RESP_OKAY, lo, 1'b1);
            rd(IDX_IRQ_FLAGS, RESP_OKAY, 8'h00, 1'b1);
         end
      end
      // Trigger on the very edge at which a byte write lands
      compare_one_mode <= TRIGGER_MODE;
      wr(IDX_COUNT_LOW, 8'h55, RESP_OKAY);
      wr(IDX_COUNT_HIGH, 8'h01, RESP_OKAY);
      fork
         wr(IDX_COUNT_LOW, 8'h3c, RESP_OKAY);
         begin
            @(posedge aclk);
            compare_one_match <= 1'b1;
            @(posedge aclk);
            compare_one_match <= 1'b0;
         end
      join
      rd(IDX_COUNT_HIGH, RESP_OKAY, 8'h01, 1'b1);
      rd(IDX_COUNT_LOW, RESP_OKAY, 8'h3c, 1'b1);
      $display("trigger test done");
      wr(IDX_COUNT_LOW, 8'h00, RESP_OKAY);
      wr(IDX_CONTROL, 8'h03, RESP_OKAY);
      pulses(5, 1'b0);
      wr(IDX_CONTROL, 8'h00, RESP_OKAY);
      rd(IDX_COUNT_LOW, RESP_OKAY, 8'h05, 1'b1);
      wr(IDX_COUNT_LOW, 8'h00, RESP_OKAY);
      wr(IDX_CONTROL, 8'h0b, RESP_OKAY);
      repeat (8) @(posedge aclk);
      check("osc oe", 34'h1, 34'(crystal_output_oe));
      check("osc out", 34'h1, 34'(crystal_output_pin));
      pulses(3, 1'b1);
      wr(IDX_CONTROL, 8'h00, RESP_OKAY);
      rd(IDX_COUNT_LOW, RESP_OKAY, 8'h03, 1'b1);
      check("osc oe", 34'h0, 34'(crystal_output_oe));
      wr(IDX_COUNT_LOW, 8'h00, RESP_OKAY);
      wr(IDX_CONTROL, 8'h03, RESP_OKAY);
      sleep_mode <= 1'b1;
      pulses(3, 1'b0);
      rd(IDX_COUNT_LOW, RESP_OKAY, 8'h00, 1'b1);
      wr(IDX_CONTROL, 8'h07, RESP_OKAY);
      pulses(4, 1'b0);
      sleep_mode <= 1'b0;
      wr(IDX_CONTROL, 8'h00, RESP_OKAY);
      rd(IDX_COUNT_LOW, RESP_OKAY, 8'h04, 1'b1);
      $display("external source test done");
      repeat (4) @(posedge aclk);
      test_done();
   end
endmodule

// >>> hw/pin_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module pin_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin_in,
   output logic pin_out
);
   logic meta_q;
   // Meta stage feeds only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b0;
         pin_out <= 1'b0;
      end else begin
         meta_q <= pin_in;
         pin_out <= meta_q;
      end
   end
endmodule

// >>> hw/timer_counter.sv
// Top of the 16-bit timer/counter with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
module timer_counter
   import timer_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_mode,
   input wire logic external_count_input,
   input wire logic crystal_input_pin,
   output logic crystal_output_pin,
   output logic crystal_output_oe,
   input wire logic [3:0] compare_one_mode,
   input wire logic compare_one_match,
   input wire logic [3:0] compare_two_mode,
   input wire logic compare_two_match,
   output logic overflow_irq,
   output logic wake_request
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] control_q;
   logic [7:0] int_control_q;
   logic [7:0] irq_enables_q;
   logic overflow_flag_q;
   logic [15:0] count_q;
   logic [2:0] pre_q;
   logic src_prev_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic ext_sync;
   logic xtal_sync;
   logic src_level;
   logic edge_in;
   logic pre_out;
   logic inc;
   logic trigger;
   logic trig_eff;
   logic wr_fire;
   logic [IDX_W-1:0] wr_idx;
   logic [IDX_W-1:0] rd_idx;
   logic wr_low;
   logic wr_high;
   logic wr_flags;
   logic wr_lane;
   logic [2:0] pre_mask;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wr_hit;
   logic run;
   logic ext_mode;
   logic bypass;

   // ----------------------------------------------------------------
   // Pin inputs
   // ----------------------------------------------------------------
   // Async count input is resolved here, so a byte read never sees
   // a half-settled count
   pin_sync u_ext_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(external_count_input),
      .pin_out(ext_sync)
   );
   pin_sync u_xtal_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(crystal_input_pin),
      .pin_out(xtal_sync)
   );

   // ----------------------------------------------------------------
   // Count path
   // ----------------------------------------------------------------
   assign run = control_q[CTL_RUN];
   assign ext_mode = control_q[CTL_SRC];
   assign bypass = control_q[CTL_BYPASS];
   assign src_level = control_q[CTL_OSC] ? xtal_sync : ext_sync;
   // Instruction clock stops in sleep; external edges do not
   assign edge_in = ext_mode ? (src_level & ~src_prev_q)
                             : ~sleep_mode;

   always_comb begin
      case (control_q[CTL_PS_LSB +: CTL_PS_W])
         2'b00: pre_mask = PRE_ZERO;
         2'b01: pre_mask = PRE_MASK1;
         2'b10: pre_mask = PRE_MASK2;
         2'b11: pre_mask = PRE_MASK3;
         default: pre_mask = PRE_ZERO;
      endcase
   end

   assign pre_out = run & edge_in & ((pre_q & pre_mask) == pre_mask);
   // Synced mode sleeps after the prescaler; bypass keeps counting
   assign inc = pre_out & ~(ext_mode & ~bypass & sleep_mode);
   assign trigger = (compare_one_match & (compare_one_mode == TRIGGER_MODE))
                  | (compare_two_match
                     & (compare_two_mode == TRIGGER_MODE));
   // Clear is dropped outright in async mode rather than left racy
   assign trig_eff = trigger & ~(ext_mode & bypass);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_prev_q <= 1'b0;
      end else begin
         src_prev_q <= src_level;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_q <= PRE_ZERO;
      end else if (wr_low || wr_high) begin
         pre_q <= PRE_ZERO;
      end else if (run && edge_in) begin
         pre_q <= pre_out ? PRE_ZERO : pre_q + PRE_ONE;
      end
   end

   // No reset on purpose: the count survives every reset
   always_ff @(posedge aclk) begin
      if (wr_low || wr_high) begin
         // Byte write wins over trigger and increment
         if (wr_low) begin
            count_q[7:0] <= wdata_q[7:0];
         end
         if (wr_high) begin
            count_q[15:8] <= wdata_q[7:0];
         end
      end else if (trig_eff) begin
         count_q <= COUNT_ZERO;
      end else if (inc) begin
         count_q <= count_q + COUNT_ONE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_flag_q <= 1'b0;
      end else if (inc && !trig_eff && !wr_low && !wr_high
                   && count_q == COUNT_MAX) begin
         overflow_flag_q <= 1'b1;
      end else if (wr_flags) begin
         overflow_flag_q <= wdata_q[OVF_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Control and plain registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_q <= CTL_RESET;
      end else if (wr_fire && wr_lane && wr_idx == IDX_CONTROL) begin
         control_q <= wdata_q[7:0] & CTL_MASK;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_control_q <= BYTE_RESET;
         irq_enables_q <= BYTE_RESET;
      end else if (wr_fire && wr_lane) begin
         if (wr_idx == IDX_INT_CONTROL) begin
            int_control_q <= wdata_q[7:0];
         end
         if (wr_idx == IDX_IRQ_ENABLES) begin
            irq_enables_q <= wdata_q[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs to pins and core
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crystal_output_pin <= 1'b0;
         crystal_output_oe <= 1'b0;
         overflow_irq <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         // Amplifier ignores sleep; off when disabled to save power
         crystal_output_oe <= control_q[CTL_OSC];
         crystal_output_pin <= control_q[CTL_OSC] & ~xtal_sync;
         overflow_irq <= overflow_flag_q
                         & irq_enables_q[OVF_BIT];
         wake_request <= sleep_mode & overflow_flag_q
                         & irq_enables_q[OVF_BIT];
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   assign wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid;
   assign wr_idx = awaddr_q[IDX_LSB +: IDX_W];
   assign wr_lane = wstrb_q[0];
   assign wr_low = wr_fire & wr_lane & (wr_idx == IDX_COUNT_LOW);
   assign wr_high = wr_fire & wr_lane & (wr_idx == IDX_COUNT_HIGH);
   assign wr_flags = wr_fire & wr_lane & (wr_idx == IDX_IRQ_FLAGS);
   assign wr_hit = (wr_idx == IDX_INT_CONTROL) | (wr_idx == IDX_IRQ_FLAGS)
                 | (wr_idx == IDX_COUNT_LOW) | (wr_idx == IDX_COUNT_HIGH)
                 | (wr_idx == IDX_CONTROL) | (wr_idx == IDX_IRQ_ENABLES);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= WORD_ZERO;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   assign rd_idx = s_axi_araddr[IDX_LSB +: IDX_W];

   always_comb begin
      rd_word = WORD_ZERO;
      rd_hit = 1'b1;
      case (rd_idx)
         IDX_INT_CONTROL: rd_word[7:0] = int_control_q;
         IDX_IRQ_FLAGS: rd_word[OVF_BIT] = overflow_flag_q;
         IDX_COUNT_LOW: rd_word[7:0] = count_q[7:0];
         IDX_COUNT_HIGH: rd_word[7:0] = count_q[15:8];
         IDX_CONTROL: rd_word[7:0] = control_q;
         IDX_IRQ_ENABLES: rd_word[7:0] = irq_enables_q;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= WORD_ZERO;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   wrap_sets_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      inc && !trig_eff && !wr_low && !wr_high && count_q == COUNT_MAX
      |=> overflow_flag_q && count_q == COUNT_ZERO)
      else $error("wrap did not set overflow flag");

   irq_gated_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !irq_enables_q[OVF_BIT] ##1 !irq_enables_q[OVF_BIT]
      |-> !overflow_irq)
      else $error("interrupt raised while disabled");

   timer_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
      run && !ext_mode && !sleep_mode && pre_mask == PRE_ZERO
      && !trig_eff && !wr_low && !wr_high
      |=> count_q == $past(count_q) + COUNT_ONE)
      else $error("timer mode did not step every cycle");

   prescale_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pre_out && pre_mask != PRE_ZERO ##1 pre_mask != PRE_ZERO
      |-> !pre_out)
      else $error("prescaler fired twice in a row");

   sleep_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sleep_mode && ext_mode && !bypass && !trig_eff
      && !wr_low && !wr_high |=> $stable(count_q))
      else $error("synced counter moved in sleep");

   trig_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      trigger && !(ext_mode && bypass) && !wr_low && !wr_high
      |=> count_q == COUNT_ZERO)
      else $error("trigger did not clear count");

   trig_noflag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      trig_eff && !overflow_flag_q && !wr_flags
      |=> !overflow_flag_q)
      else $error("trigger clear set overflow flag");

   write_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_low && trig_eff |=> count_q[7:0] == $past(wdata_q[7:0]))
      else $error("trigger beat software write");

   stop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !run && !trig_eff && !wr_low && !wr_high
      |=> $stable(count_q) && !$rose(overflow_flag_q))
      else $error("stopped counter moved");

   flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
      overflow_flag_q && !wr_flags |=> overflow_flag_q)
      else $error("overflow flag dropped without write");

   pre_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_low || wr_high |=> pre_q == PRE_ZERO)
      else $error("count write left prescaler");
endmodule

// >>> hw/timer_pkg.sv
// Constants, register map and field layout of the 16-bit timer/counter
package timer_pkg;
   // ----------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_INT_CONTROL = 8'h0b;
   localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
   localparam logic [7:0] IDX_COUNT_LOW = 8'h0e;
   localparam logic [7:0] IDX_COUNT_HIGH = 8'h0f;
   localparam logic [7:0] IDX_CONTROL = 8'h10;
   localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 8;
   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int CTL_RUN = 0;
   localparam int CTL_SRC = 1;
   localparam int CTL_BYPASS = 2;
   localparam int CTL_OSC = 3;
   localparam int CTL_PS_LSB = 4;
   localparam int CTL_PS_W = 2;
   localparam logic [7:0] CTL_MASK = 8'h3f;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam int OVF_BIT = 0;
   localparam logic [3:0] TRIGGER_MODE = 4'hb;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [2:0] PRE_ZERO = 3'h0;
   localparam logic [2:0] PRE_ONE = 3'h1;
   localparam logic [2:0] PRE_MASK1 = 3'h1;
   localparam logic [2:0] PRE_MASK2 = 3'h3;
   localparam logic [2:0] PRE_MASK3 = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage
